/* File: verif/scai_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Controller side: one command per call, launched just after an edge
module scai_host_model (
    input wire logic clk_sys,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic bank_sel_lsb,
    output logic bank_sel_msb,
    output logic [12:0] addr_bus,
    output logic [3:0] byte_mask,
    output logic [31:0] dq_in
);
    // Idle, deselected, clock enabled at time zero
    initial
    begin
        {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
        {bank_sel_msb, bank_sel_lsb, addr_bus, byte_mask, dq_in} = '0;
    end

    // Drive one command; the device takes it at the next rising edge
    task automatic cmd(input logic c_cs, input logic c_cke, input logic [2:0] c, input logic [1:0] b,
        input logic [12:0] a, input logic [3:0] m, input logic [31:0] d);
        @(posedge clk_sys);
        cs_n <= c_cs;
        cke <= c_cke;
        {ras_n, cas_n, we_n} <= c;
        {bank_sel_msb, bank_sel_lsb} <= b;
        addr_bus <= a;
        byte_mask <= m;
        dq_in <= d; // Write word, also on later burst steps
    endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    logic clk_sys;
    logic rst_n;
    int num_errors = 0;
    int n_tests = 0;
    wire logic cke, cs_n, ras_n, cas_n, we_n, bsl, bsm;
    wire logic [12:0] addr_bus;
    wire logic [3:0] byte_mask;
    wire logic [31:0] dq_in;
    logic [31:0] dq_out;
    logic [3:0] dq_oe;
    logic [3:0] banks_open;
    logic pd, sr, ds, wake, rtick;
    logic [14:0] raddr;

    scai_host_model host_u (.clk_sys(clk_sys), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .bank_sel_lsb(bsl), .bank_sel_msb(bsm), .addr_bus(addr_bus), .byte_mask(byte_mask),
        .dq_in(dq_in));
    scai_top #(.SREF_BASE_CYC(4)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_sel_lsb(bsl), .bank_sel_msb(bsm),
        .addr_bus(addr_bus), .byte_mask(byte_mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .banks_open(banks_open), .power_down_active(pd), .self_refresh_active(sr),
        .deep_sleep_active(ds), .wake_detect(wake), .refresh_tick(rtick), .refresh_addr(raddr));

    // Idle cycles with a chosen clock gate level
    task automatic idle(input int n, input logic k);
        repeat (n) host_u.cmd(1'b0, k, scai_pkg::CMD_NOP, 2'h0, 13'h0000, 4'h0, 32'h0);
    endtask

    // Open, full write, masked write, masked read at latency two
    task automatic t_read_write;
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_ROW_OPEN, 2'h1, 13'h0005, 4'h0, 32'h0);
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_WRITE, 2'h1, 13'h0003, 4'h0, 32'h11223344);
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_WRITE, 2'h1, 13'h0003, 4'h1, 32'hAABBCCDD);
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_READ, 2'h1, 13'h0003, 4'h3, 32'h0);
        idle(2, 1'b1);
        #1 `CHK(dq_oe, 4'h0)
        @(posedge clk_sys);
        #1 `CHK(dq_oe, 4'hC)
        `CHK(dq_out, 32'hAABBCC44)
        `CHK(banks_open, 4'h2)
    endtask

    // Single-bank close, deselected command, close all, latency three
    task automatic t_banks_mode;
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_ROW_OPEN, 2'h2, 13'h0007, 4'h0, 32'h0);
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_PRECHARGE, 2'h1, 13'h0000, 4'h0, 32'h0);
        host_u.cmd(1'b1, 1'b1, scai_pkg::CMD_ROW_OPEN, 2'h0, 13'h0001, 4'h0, 32'h0);
        idle(2, 1'b1);
        #1 `CHK(banks_open, 4'h4)
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_PRECHARGE, 2'h0, 13'h0400, 4'h0, 32'h0);
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_MODE_LOAD, 2'h0, 13'h0030, 4'h0, 32'h0);
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_ROW_OPEN, 2'h1, 13'h0005, 4'h0, 32'h0);
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_READ, 2'h1, 13'h0003, 4'h0, 32'h0);
        idle(3, 1'b1);
        #1 `CHK(dq_oe, 4'h0)
        @(posedge clk_sys);
        #1 `CHK(dq_oe, 4'hF)
        `CHK(dq_out, 32'hAABBCC44)
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_PRECHARGE, 2'h0, 13'h0400, 4'h0, 32'h0);
        idle(2, 1'b1);
        #1 `CHK(banks_open, 4'h0)
    endtask

    // Low-power entry chosen by command, inputs ignored, exit on clock gate
    task automatic t_low_power(input logic [2:0] c, input logic [2:0] flags);
        host_u.cmd(1'b0, 1'b0, c, 2'h0, 13'h0000, 4'h0, 32'h0);
        host_u.cmd(1'b0, 1'b0, scai_pkg::CMD_ROW_OPEN, 2'h3, 13'h0009, 4'h0, 32'h0);
        idle(2, 1'b0);
        #1 `CHK({ds, sr, pd}, flags)
        `CHK(banks_open, 4'h0)
        `CHK(wake, 1'b0)
        idle(1, 1'b1);
        #1 `CHK(wake, 1'b1)
        idle(2, 1'b1);
        #1 `CHK({ds, sr, pd}, 3'h0)
    endtask

    // Interleaved burst of four, auto-precharge, suspend mid-read, auto refresh
    task automatic t_burst;
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_MODE_LOAD, 2'h0, 13'h002A, 4'h0, 32'h0);
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_ROW_OPEN, 2'h2, 13'h0011, 4'h0, 32'h0);
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_WRITE, 2'h2, 13'h0401, 4'h0, 32'h000000A0);
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_NOP, 2'h0, 13'h0000, 4'h0, 32'h000000A1);
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_NOP, 2'h0, 13'h0000, 4'h0, 32'h000000A2);
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_NOP, 2'h0, 13'h0000, 4'h0, 32'h000000A3);
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_ROW_OPEN, 2'h2, 13'h0011, 4'h0, 32'h0);
        #1 `CHK(banks_open, 4'h0)
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_READ, 2'h2, 13'h0002, 4'h0, 32'h0);
        idle(3, 1'b1);
        #1 `CHK(dq_out, 32'h000000A3)
        idle(1, 1'b0);
        #1 `CHK(dq_out, 32'h000000A2)
        idle(1, 1'b0);
        #1 `CHK(dq_out, 32'h000000A1)
        idle(2, 1'b1);
        #1 `CHK(dq_out, 32'h000000A1)
        `CHK(dq_oe, 4'hF)
        idle(1, 1'b1);
        #1 `CHK(dq_out, 32'h000000A0)
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_PRECHARGE, 2'h0, 13'h0400, 4'h0, 32'h0);
        host_u.cmd(1'b0, 1'b1, scai_pkg::CMD_AUTO_REFRESH, 2'h0, 13'h0000, 4'h0, 32'h0);
        idle(1, 1'b1);
        #1 `CHK(raddr, 15'h0001)
        `CHK(rtick, 1'b0)
        `CHK(banks_open, 4'h0)
    endtask

    // Verdict and end of run
    task automatic tally_and_finish;
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Free-running clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        idle(2, 1'b1);
        t_read_write();
        t_banks_mode();
        t_burst();
        t_low_power(scai_pkg::CMD_NOP, 3'b001);
        t_low_power(scai_pkg::CMD_AUTO_REFRESH, 3'b010);
        t_low_power(scai_pkg::CMD_BURST_STOP, 3'b100);
        `CHK(raddr, 15'h0003)
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* File: verilog/scai_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module scai_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    logic [WIDTH-1:0] store_r [0:DEPTH-1];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    wire push_w;
    wire pop_w;

    // Honest full and empty from the word count
    assign in_ready = (count_r != FULL_CNT);
    assign out_valid = (count_r != '0);
    assign out_data = store_r[rd_ptr_r];
    assign push_w = in_valid && in_ready;
    assign pop_w = out_valid && out_ready;

    // Storage write
    always_ff @(posedge clk_sys)
    begin
        if (push_w)
            store_r[wr_ptr_r] <= in_data;
    end

    // Pointers and count
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push_w)
                wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : PW'(wr_ptr_r + 1'b1);
            if (pop_w)
                rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : PW'(rd_ptr_r + 1'b1);
            if (push_w && !pop_w)
                count_r <= CW'(count_r + 1'b1);
            else if (pop_w && !push_w)
                count_r <= CW'(count_r - 1'b1);
        end
    end
endmodule
`default_nettype wire

/* File: verilog/scai_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module scai_mem (
    input wire logic clk_sys,
    input wire logic mem_en,
    input wire logic mem_we,
    input wire logic [scai_pkg::MASK_W-1:0] mem_be,
    input wire logic [scai_pkg::MEM_AW-1:0] mem_addr,
    input wire logic [scai_pkg::DATA_W-1:0] mem_wdata,
    output logic [scai_pkg::DATA_W-1:0] mem_rdata_r
);
    // One word per bank, row and column triple, split into byte lanes
    // so that each lane array has a single writing process
    genvar b;
    generate
        for (b = 0; b < scai_pkg::MASK_W; b++)
        begin : g_lane
            logic [7:0] lane [0:(1 << scai_pkg::MEM_AW)-1];
            // Byte-enabled write and registered read of this lane
            always_ff @(posedge clk_sys)
            begin
                if (mem_en && mem_we && mem_be[b])
                    lane[mem_addr] <= mem_wdata[b*8 +: 8];
                if (mem_en && !mem_we)
                    mem_rdata_r[b*8 +: 8] <= lane[mem_addr];
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* File: verilog/scai_pkg.sv */
`default_nettype none
package scai_pkg;
    // Array geometry
    localparam int BANK_W = 2;
    localparam int ROW_W = 13;
    localparam int COL_W = 9;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 32;
    localparam int MASK_W = 4;
    localparam int MEM_AW = BANK_W + ROW_W + COL_W;
    localparam int NUM_BANKS = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int RSH_W = BANK_W + ROW_W;

    // Command codes on {row strobe, column strobe, write enable}
    localparam logic [2:0] CMD_MODE_LOAD = 3'h0;
    localparam logic [2:0] CMD_AUTO_REFRESH = 3'h1;
    localparam logic [2:0] CMD_PRECHARGE = 3'h2;
    localparam logic [2:0] CMD_ROW_OPEN = 3'h3;
    localparam logic [2:0] CMD_WRITE = 3'h4;
    localparam logic [2:0] CMD_READ = 3'h5;
    localparam logic [2:0] CMD_BURST_STOP = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // Address bit position and bank select codes for mode loads
    localparam int AP_BIT = 10;
    localparam logic [1:0] SEL_MODE = 2'h0;
    localparam logic [1:0] SEL_EXT_MODE = 2'h2;

    // Mode configuration fields
    localparam int BL_LSB = 0;
    localparam int BT_BIT = 3;
    localparam int CL_LSB = 4;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [9:0] LEN_1 = 10'h001;
    localparam logic [9:0] LEN_2 = 10'h002;
    localparam logic [9:0] LEN_4 = 10'h004;
    localparam logic [9:0] LEN_8 = 10'h008;
    localparam logic [9:0] LEN_FULL = 10'h200;
    localparam logic [2:0] CL_3 = 3'h3;
    localparam logic [ADDR_W-1:0] MODE_RST = 13'h0020;

    // Extended configuration fields
    localparam int PARTIAL_ARRAY_REFRESH_LSB = 0;
    localparam int TEMP_COMP_REFRESH_LSB = 3;
    localparam logic [2:0] PARTIAL_ARRAY_REFRESH_HALF = 3'h1;
    localparam logic [2:0] PARTIAL_ARRAY_REFRESH_QUARTER = 3'h2;
    localparam logic [2:0] PARTIAL_ARRAY_REFRESH_EIGHTH = 3'h5;
    localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SIXTEENTH = 3'h6;
    localparam logic [RSH_W-1:0] RSH_LAST_FULL = 15'h7FFF;
    localparam logic [RSH_W-1:0] RSH_LAST_HALF = 15'h3FFF;
    localparam logic [RSH_W-1:0] RSH_LAST_QUARTER = 15'h1FFF;
    localparam logic [RSH_W-1:0] RSH_LAST_EIGHTH = 15'h0FFF;
    localparam logic [RSH_W-1:0] RSH_LAST_SIXTEENTH = 15'h07FF;
    localparam logic [ADDR_W-1:0] EXT_MODE_RST = 13'h0000;

    // Self-refresh timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SREF_BASE_NS = 7812;
    localparam int SREF_BASE_CYC = SREF_BASE_NS / CLK_PERIOD_NS;

    // Power states
    typedef enum logic [3:0] {
        ST_ACTIVE = 4'h1,
        ST_POWER_DOWN = 4'h2,
        ST_SELF_REFRESH = 4'h4,
        ST_DEEP_SLEEP = 4'h8
    } scai_state_e;
endpackage
`default_nettype wire

/* File: verilog/scai_top.sv */
`timescale 1ns/1ps
`default_nettype none
module scai_top #(
    parameter int SREF_BASE_CYC = scai_pkg::SREF_BASE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_sel_lsb,
    input wire logic bank_sel_msb,
    input wire logic [scai_pkg::ADDR_W-1:0] addr_bus,
    input wire logic [scai_pkg::MASK_W-1:0] byte_mask,
    input wire logic [scai_pkg::DATA_W-1:0] dq_in,
    output logic [scai_pkg::DATA_W-1:0] dq_out,
    output logic [scai_pkg::MASK_W-1:0] dq_oe,
    output logic [scai_pkg::NUM_BANKS-1:0] banks_open,
    output logic power_down_active,
    output logic self_refresh_active,
    output logic deep_sleep_active,
    output logic wake_detect,
    output logic refresh_tick,
    output logic [scai_pkg::RSH_W-1:0] refresh_addr
);
    localparam int SC_W = 16;
    localparam logic [SC_W-1:0] SREF_BASE = SC_W'(SREF_BASE_CYC);

    scai_pkg::scai_state_e st_r;
    scai_pkg::scai_state_e st_nxt;
    logic cke_r;
    logic [scai_pkg::ADDR_W-1:0] mode_r;
    logic [scai_pkg::ADDR_W-1:0] ext_mode_r;
    logic [scai_pkg::NUM_BANKS-1:0] banks_open_r;
    logic [scai_pkg::ROW_W-1:0] open_row_r [0:scai_pkg::NUM_BANKS-1];
    logic burst_active_r;
    logic burst_wr_r;
    logic burst_ap_r;
    logic [scai_pkg::BANK_W-1:0] burst_bank_r;
    logic [scai_pkg::ROW_W-1:0] burst_row_r;
    logic [scai_pkg::COL_W-1:0] burst_start_r;
    logic [9:0] burst_cnt_r;
    logic mem_rvalid_r;
    logic [2:0] due_r;
    logic [scai_pkg::MASK_W-1:0] mask_d1_r;
    logic [scai_pkg::MASK_W-1:0] mask_d2_r;
    logic [scai_pkg::DATA_W-1:0] dq_out_r;
    logic [scai_pkg::MASK_W-1:0] dq_oe_r;
    logic rd_word_r;
    logic [SC_W-1:0] sref_cnt_r;
    logic [scai_pkg::RSH_W-1:0] refresh_addr_r;
    logic refresh_tick_r;
    logic [scai_pkg::DATA_W-1:0] mem_rdata_r;
    logic [scai_pkg::DATA_W-1:0] fifo_head;
    logic fifo_in_ready;
    logic fifo_out_valid;

    // Internal clock enable: clock-gate sampled low suspends from next cycle
    wire st_active = (st_r == scai_pkg::ST_ACTIVE);
    wire en = cke_r && st_active;
    wire [scai_pkg::BANK_W-1:0] bank_in = {bank_sel_msb, bank_sel_lsb};
    wire [2:0] cmd = {ras_n, cas_n, we_n};
    wire cmd_ok = en && !cs_n;
    wire rw_go = cmd_ok && (cmd == scai_pkg::CMD_READ || cmd == scai_pkg::CMD_WRITE);
    wire act_go = cmd_ok && (cmd == scai_pkg::CMD_ROW_OPEN);
    wire pre_go = cmd_ok && (cmd == scai_pkg::CMD_PRECHARGE);
    wire bst_go = cmd_ok && (cmd == scai_pkg::CMD_BURST_STOP);
    wire ref_go = cmd_ok && (cmd == scai_pkg::CMD_AUTO_REFRESH);
    wire all_idle = (banks_open_r == '0) && !burst_active_r;
    wire lmr_go = cmd_ok && (cmd == scai_pkg::CMD_MODE_LOAD) && all_idle;
    wire ap_in = addr_bus[scai_pkg::AP_BIT];

    // Low-power entry choices while idle
    wire lp_go = en && !cke && all_idle;
    wire pd_go = lp_go && (cs_n || cmd == scai_pkg::CMD_NOP);
    wire sref_go = lp_go && ref_go;
    wire deep_go = lp_go && bst_go;
    // Exit comes from the clock-gate level, no other input is looked at
    wire wake = !st_active && cke;

    // Mode fields
    wire [2:0] bl_code = mode_r[scai_pkg::BL_LSB +: 3];
    wire bt_ilv = mode_r[scai_pkg::BT_BIT];
    wire cl3 = (mode_r[scai_pkg::CL_LSB +: 3] == scai_pkg::CL_3);
    wire [2:0] partial_array_refresh = ext_mode_r[scai_pkg::PARTIAL_ARRAY_REFRESH_LSB +: 3];
    wire [1:0] temp_comp_refresh = ext_mode_r[scai_pkg::TEMP_COMP_REFRESH_LSB +: 2];

    // Burst length and column ordering
    wire [9:0] blen = (bl_code == scai_pkg::BL_1) ? scai_pkg::LEN_1 :
        (bl_code == scai_pkg::BL_2) ? scai_pkg::LEN_2 :
        (bl_code == scai_pkg::BL_4) ? scai_pkg::LEN_4 :
        (bl_code == scai_pkg::BL_8) ? scai_pkg::LEN_8 :
        (bl_code == scai_pkg::BL_FULL) ? scai_pkg::LEN_FULL : scai_pkg::LEN_1;
    wire full_page = (bl_code == scai_pkg::BL_FULL);
    wire [scai_pkg::COL_W-1:0] bmask = scai_pkg::COL_W'(blen - scai_pkg::LEN_1);
    wire [scai_pkg::COL_W-1:0] seq_col = scai_pkg::COL_W'(burst_start_r + burst_cnt_r[8:0]);
    wire [scai_pkg::COL_W-1:0] ilv_col = burst_start_r ^ burst_cnt_r[8:0];
    wire [scai_pkg::COL_W-1:0] step_col = (bt_ilv && !full_page) ? ilv_col : seq_col;
    wire [scai_pkg::COL_W-1:0] burst_col = (burst_start_r & ~bmask) | (step_col & bmask);
    wire [9:0] cnt_inc = 10'(burst_cnt_r + 10'h001);
    wire step_go = en && burst_active_r && !rw_go && !bst_go && (burst_wr_r || fifo_in_ready);
    wire burst_last = step_go && (cnt_inc == blen);

    // Array access: command word straight from pins, later words from the counter
    wire mem_en = rw_go || step_go;
    wire mem_we = rw_go ? (cmd == scai_pkg::CMD_WRITE) : burst_wr_r;
    wire [scai_pkg::MEM_AW-1:0] mem_addr = rw_go ?
        {bank_in, open_row_r[bank_in], addr_bus[scai_pkg::COL_W-1:0]} :
        {burst_bank_r, burst_row_r, burst_col};
    wire [scai_pkg::MASK_W-1:0] mem_be = ~byte_mask;
    wire rd_issue = mem_en && !mem_we;

    // Auto-precharge close at the end of a burst
    wire ap_close = (rw_go && blen == scai_pkg::LEN_1 && ap_in) || (burst_last && burst_ap_r);
    wire [scai_pkg::BANK_W-1:0] close_bank = rw_go ? bank_in : burst_bank_r;

    // Output release after the programmed latency
    wire pop_w = en && (cl3 ? due_r[2] : due_r[1]) && fifo_out_valid;

    // Self-refresh interval and covered fraction
    wire [SC_W-1:0] sref_int = SC_W'(SREF_BASE << temp_comp_refresh);
    wire sref_tick_w = self_refresh_active && (sref_cnt_r >= SC_W'(sref_int - 1'b1));
    wire [scai_pkg::RSH_W-1:0] rsh_last = (partial_array_refresh == scai_pkg::PARTIAL_ARRAY_REFRESH_HALF) ? scai_pkg::RSH_LAST_HALF :
        (partial_array_refresh == scai_pkg::PARTIAL_ARRAY_REFRESH_QUARTER) ? scai_pkg::RSH_LAST_QUARTER :
        (partial_array_refresh == scai_pkg::PARTIAL_ARRAY_REFRESH_EIGHTH) ? scai_pkg::RSH_LAST_EIGHTH :
        (partial_array_refresh == scai_pkg::PARTIAL_ARRAY_REFRESH_SIXTEENTH) ? scai_pkg::RSH_LAST_SIXTEENTH :
        scai_pkg::RSH_LAST_FULL;
    wire rsh_adv = sref_tick_w || ref_go;

    assign dq_out = dq_out_r;
    assign dq_oe = dq_oe_r;
    assign banks_open = banks_open_r;
    assign power_down_active = (st_r == scai_pkg::ST_POWER_DOWN);
    assign self_refresh_active = (st_r == scai_pkg::ST_SELF_REFRESH);
    assign deep_sleep_active = (st_r == scai_pkg::ST_DEEP_SLEEP);
    assign wake_detect = wake;
    assign refresh_tick = refresh_tick_r;
    assign refresh_addr = refresh_addr_r;

    // Power state selection
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            scai_pkg::ST_ACTIVE:
            begin
                if (sref_go)
                    st_nxt = scai_pkg::ST_SELF_REFRESH;
                else if (deep_go)
                    st_nxt = scai_pkg::ST_DEEP_SLEEP;
                else if (pd_go)
                    st_nxt = scai_pkg::ST_POWER_DOWN;
            end
            scai_pkg::ST_POWER_DOWN,
            scai_pkg::ST_SELF_REFRESH,
            scai_pkg::ST_DEEP_SLEEP:
            begin
                if (wake)
                    st_nxt = scai_pkg::ST_ACTIVE;
            end
            default: st_nxt = scai_pkg::ST_ACTIVE;
        endcase
    end

    // Clock-gate sampling and power state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cke_r <= 1'b0;
            st_r <= scai_pkg::ST_ACTIVE;
        end
        else
        begin
            cke_r <= cke;
            st_r <= st_nxt;
        end
    end

    // Mode settings, kept until the next load
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_r <= scai_pkg::MODE_RST;
            ext_mode_r <= scai_pkg::EXT_MODE_RST;
        end
        else if (lmr_go && bank_in == scai_pkg::SEL_MODE)
            mode_r <= addr_bus;
        else if (lmr_go && bank_in == scai_pkg::SEL_EXT_MODE)
            ext_mode_r <= addr_bus;
    end

    // Per-bank open state and row address
    genvar b;
    generate
        for (b = 0; b < scai_pkg::NUM_BANKS; b++)
        begin : g_bank
            wire sel = (bank_in == scai_pkg::BANK_W'(b));
            wire clr = (pre_go && (ap_in || sel)) || (ap_close && close_bank == scai_pkg::BANK_W'(b));
            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    banks_open_r[b] <= 1'b0;
                    open_row_r[b] <= '0;
                end
                else if (act_go && sel)
                begin
                    banks_open_r[b] <= 1'b1;
                    open_row_r[b] <= addr_bus;
                end
                else if (clr)
                    banks_open_r[b] <= 1'b0;
            end
        end
    endgenerate

    // Burst engine
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            burst_active_r <= 1'b0;
            burst_wr_r <= 1'b0;
            burst_ap_r <= 1'b0;
            burst_bank_r <= '0;
            burst_row_r <= '0;
            burst_start_r <= '0;
            burst_cnt_r <= '0;
        end
        else if (rw_go)
        begin
            burst_active_r <= (blen != scai_pkg::LEN_1);
            burst_wr_r <= (cmd == scai_pkg::CMD_WRITE);
            burst_ap_r <= ap_in;
            burst_bank_r <= bank_in;
            burst_row_r <= open_row_r[bank_in];
            burst_start_r <= addr_bus[scai_pkg::COL_W-1:0];
            burst_cnt_r <= scai_pkg::LEN_1;
        end
        else if (bst_go)
            burst_active_r <= 1'b0;
        else if (step_go)
        begin
            burst_cnt_r <= cnt_inc;
            if (burst_last)
                burst_active_r <= 1'b0;
        end
    end

    // Read pipeline: frozen while the clock gate suspends it, output enable dropped in low-power states
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_rvalid_r <= 1'b0;
            due_r <= '0;
            mask_d1_r <= '0;
            mask_d2_r <= '0;
            dq_out_r <= '0;
            dq_oe_r <= '0;
            rd_word_r <= 1'b0;
        end
        else if (en)
        begin
            mem_rvalid_r <= rd_issue;
            due_r <= {due_r[1:0], rd_issue};
            mask_d1_r <= byte_mask;
            mask_d2_r <= mask_d1_r;
            rd_word_r <= pop_w;
            dq_oe_r <= pop_w ? ~mask_d2_r : '0;
            if (pop_w)
                dq_out_r <= fifo_head;
        end
        else if (!st_active)
        begin
            dq_oe_r <= '0;
            rd_word_r <= 1'b0;
        end
    end

    // Self-refresh timer and refresh row counter
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sref_cnt_r <= '0;
            refresh_addr_r <= '0;
            refresh_tick_r <= 1'b0;
        end
        else
        begin
            refresh_tick_r <= sref_tick_w;
            sref_cnt_r <= (sref_tick_w || !self_refresh_active) ? '0 : SC_W'(sref_cnt_r + 1'b1);
            if (rsh_adv)
                refresh_addr_r <= (refresh_addr_r >= rsh_last) ? '0 :
                    scai_pkg::RSH_W'(refresh_addr_r + 1'b1);
        end
    end

    scai_mem u_mem (
        .clk_sys(clk_sys),
        .mem_en(mem_en),
        .mem_we(mem_we),
        .mem_be(mem_be),
        .mem_addr(mem_addr),
        .mem_wdata(dq_in),
        .mem_rdata_r(mem_rdata_r)
    );

    scai_fifo #(
        .WIDTH(scai_pkg::DATA_W),
        .DEPTH(scai_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(en && mem_rvalid_r),
        .in_ready(fifo_in_ready),
        .in_data(mem_rdata_r),
        .out_valid(fifo_out_valid),
        .out_ready(pop_w),
        .out_data(fifo_head)
    );

    // Assertions
    wire rd_go_s = rw_go && (cmd == scai_pkg::CMD_READ) && fifo_in_ready;
    sequence s_rd_cl2;
        rd_go_s && !cl3 ##1 en ##1 en;
    endsequence
    sequence s_rd_cl3;
        rd_go_s && cl3 ##1 en ##1 en ##1 en;
    endsequence

    a_suspend_freeze: assert property (@(posedge clk_sys) disable iff (!rst_n) !en |=> $stable(dq_out_r) && $stable(burst_cnt_r)) else $error("state moved while suspended");
    a_gate_next_cycle: assert property (@(posedge clk_sys) disable iff (!rst_n) st_active && !cke |=> !en) else $error("suspend not taken next cycle");
    a_latency_two: assert property (@(posedge clk_sys) disable iff (!rst_n) s_rd_cl2 |=> rd_word_r) else $error("read word late at latency two");
    a_latency_three: assert property (@(posedge clk_sys) disable iff (!rst_n) s_rd_cl3 |=> rd_word_r) else $error("read word late at latency three");
    a_out_from_pop: assert property (@(posedge clk_sys) disable iff (!rst_n) !pop_w |=> $stable(dq_out_r)) else $error("output changed without release");
    a_mask_blank: assert property (@(posedge clk_sys) disable iff (!rst_n) en && byte_mask[0] ##1 en ##1 (en && pop_w) |=> !dq_oe_r[0]) else $error("masked byte driven");
    a_precharge_all: assert property (@(posedge clk_sys) disable iff (!rst_n) pre_go && ap_in && !act_go |=> banks_open_r == '0) else $error("banks left open");
    a_row_latch: assert property (@(posedge clk_sys) disable iff (!rst_n) act_go |=> banks_open_r[$past(bank_in)] && open_row_r[$past(bank_in)] == $past(addr_bus)) else $error("row not latched");
    a_deselect_masks: assert property (@(posedge clk_sys) disable iff (!rst_n) cs_n && !burst_active_r |=> $stable(banks_open_r) && $stable(mode_r)) else $error("command acted while deselected");
    a_mode_load: assert property (@(posedge clk_sys) disable iff (!rst_n) lmr_go && bank_in == scai_pkg::SEL_MODE |=> mode_r == $past(addr_bus)) else $error("mode not stored");
    a_sref_entry: assert property (@(posedge clk_sys) disable iff (!rst_n) sref_go |=> self_refresh_active) else $error("self refresh not entered");
    a_lowpower_ignore: assert property (@(posedge clk_sys) disable iff (!rst_n) !st_active |=> $stable(mode_r) && $stable(banks_open_r)) else $error("input acted in low power");
endmodule
`default_nettype wire
